// File: scsp_pkg.sv
package scsp_pkg;

  // Register map
  localparam logic [7:0] SCSP_CTRL_OFFSET   = 8'hD8;
  localparam logic [7:0] SCSP_STATUS_OFFSET = 8'hD9;

  // Control register field positions
  localparam int SCSP_FAST_SOURCE_POS = 7;
  localparam int SCSP_SUB_OSC_POS     = 6;
  localparam int SCSP_SYSCLK_FAST_POS = 5;
  localparam int SCSP_SLOW_SOURCE_POS = 4;
  localparam int SCSP_SUB_HALT_POS    = 3;
  localparam int SCSP_DIVIDER_LSB     = 0;

  // Reset values
  localparam logic [7:0] SCSP_CTRL_RESET = 8'h05;
  localparam logic [2:0] SCSP_DIV_RESET  = 3'h5;

  // Prescaler codes and half-period counter width
  localparam logic [2:0] SCSP_DIV_CODE_MAX = 3'h5;
  localparam int         SCSP_CNT_W        = 5;

  // Oscillator inputs, one bit each
  localparam int SCSP_OSC_COUNT = 5;

  typedef struct packed {
    logic       fastSourcePick;
    logic       subOscPick;
    logic       sysclkFastPick;
    logic       slowSourcePick;
    logic       subOscHalt;
    logic [2:0] sysclkDivider;
  } scsp_ctrl_type;

  // Source and divider that actually drive the system clock
  typedef struct packed {
    logic       fastSel;
    logic       fastSourcePick;
    logic       subOscPick;
    logic       slowSourcePick;
    logic       subOscHalt;
    logic [2:0] divCode;
  } scsp_active_type;

  typedef struct packed {
    logic slowRc;
    logic slowCrystal;
    logic fastRc;
    logic fastCrystal;
    logic resistanceFreq;
  } scsp_osc_type;

endpackage

// File: scsp_sync.sv
module scsp_sync
  import scsp_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage1_nxt;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage2_nxt;

  initial begin
    if (W < 1) begin
      $error("scsp_sync: W must be at least 1");
    end
  end

  always_comb begin
    stage1_nxt = asyncIn;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign syncOut = stage2_r;

endmodule // scsp_sync

// File: scsp_top.sv
module scsp_top
  import scsp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrStrobe,
  input  wire logic              regRdStrobe,
  output logic      [7:0]        regRdData_r,
  // Oscillator clocks, asynchronous to mclk
  input  wire scsp_osc_type      oscIn,
  // Oscillator control and system clock
  output logic                   fastRcRun_r,
  output logic                   fastCrystalRun_r,
  output logic                   fastXtalPins_r,
  output logic                   slowXtalPins_r,
  output logic                   sysClk_r
);

  initial begin
    if (ADDR_W < 8) begin
      $error("scsp_top: ADDR_W must be at least 8");
    end
  end

  scsp_osc_type oscSync;

  scsp_sync #(
    .W       (SCSP_OSC_COUNT)
  ) u_osc_sync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (oscIn),
    .syncOut (oscSync)
  );

  // Register file
  scsp_ctrl_type ctrl_r;
  scsp_ctrl_type ctrl_nxt;
  logic [7:0]    regRdData_nxt;
  logic          ctrlWr;
  logic          ctrlRd;
  logic          statusRd;
  scsp_ctrl_type wrVal;
  logic          pending;

  assign wrVal    = scsp_ctrl_type'(regWrData);
  assign ctrlWr   = regWrStrobe && (regAddr == ADDR_W'(SCSP_CTRL_OFFSET));
  assign ctrlRd   = regRdStrobe && (regAddr == ADDR_W'(SCSP_CTRL_OFFSET));
  assign statusRd = regRdStrobe && (regAddr == ADDR_W'(SCSP_STATUS_OFFSET));

  // Clock generation state
  scsp_active_type act_r;
  scsp_active_type act_nxt;
  scsp_active_type want;
  logic [SCSP_CNT_W-1:0] cnt_r;
  logic [SCSP_CNT_W-1:0] cnt_nxt;
  logic srcPrev_r;
  logic srcPrev_nxt;
  logic sysClk_nxt;
  logic fastRcRun_nxt;
  logic fastCrystalRun_nxt;
  logic srcLvl;
  logic srcEdge;

  // Source level seen through a given selection
  function automatic logic srcLevel(scsp_active_type s, scsp_osc_type o);
    logic fastLvl;
    logic slowLvl;
    fastLvl = 1'b0;
    slowLvl = 1'b0;
    if (s.fastSourcePick) begin
      fastLvl = o.resistanceFreq;
    end else if (!s.subOscHalt) begin
      fastLvl = s.subOscPick ? o.fastCrystal : o.fastRc;
    end
    slowLvl = s.slowSourcePick ? o.slowCrystal : o.slowRc;
    return s.fastSel ? fastLvl : slowLvl;
  endfunction

  // Source half periods in one half period of the system clock, minus one
  function automatic logic [SCSP_CNT_W-1:0] halfTarget(logic [2:0] code);
    logic [SCSP_CNT_W-1:0] t;
    t = '0;
    if (code <= SCSP_DIV_CODE_MAX) begin
      t = SCSP_CNT_W'((6'h20 >> code) - 6'h01);
    end
    return t;
  endfunction

  always_comb begin
    ctrl_nxt      = ctrl_r;
    regRdData_nxt = 8'h00;
    if (ctrlWr) begin
      ctrl_nxt.sysclkDivider = wrVal.sysclkDivider;
      if (!ctrl_r.sysclkFastPick) begin
        ctrl_nxt.fastSourcePick = wrVal.fastSourcePick;
        ctrl_nxt.subOscPick     = wrVal.subOscPick;
      end
      if (!ctrl_r.subOscHalt || ctrl_r.fastSourcePick) begin
        ctrl_nxt.sysclkFastPick = wrVal.sysclkFastPick;
      end
      if (ctrl_r.sysclkFastPick) begin
        ctrl_nxt.slowSourcePick = wrVal.slowSourcePick;
      end
      if (!ctrl_r.sysclkFastPick || ctrl_r.fastSourcePick) begin
        ctrl_nxt.subOscHalt = wrVal.subOscHalt;
      end
    end
    if (ctrlRd) begin
      regRdData_nxt = ctrl_r;
    end else if (statusRd) begin
      regRdData_nxt = {pending, act_r.fastSel, act_r.divCode, 3'h0};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r      <= SCSP_CTRL_RESET;
      regRdData_r <= 8'h00;
    end else begin
      ctrl_r      <= ctrl_nxt;
      regRdData_r <= regRdData_nxt;
    end
  end

  // Source and divider settings wait at the end of a full period before they take hold; the oscillator run outputs follow ctrl_r one cycle later
  always_comb begin
    want.fastSel        = ctrl_r.sysclkFastPick;
    want.fastSourcePick = ctrl_r.fastSourcePick;
    want.subOscPick     = ctrl_r.subOscPick;
    want.slowSourcePick = ctrl_r.slowSourcePick;
    want.subOscHalt     = ctrl_r.subOscHalt;
    want.divCode        = ctrl_r.sysclkDivider;
    pending             = (want != act_r);
    srcLvl              = srcLevel(act_r, oscSync);
    srcEdge             = (srcLvl != srcPrev_r);
    act_nxt             = act_r;
    cnt_nxt             = cnt_r;
    sysClk_nxt          = sysClk_r;
    srcPrev_nxt         = srcLvl;
    fastRcRun_nxt       = !ctrl_r.subOscHalt && !ctrl_r.subOscPick;
    fastCrystalRun_nxt  = !ctrl_r.subOscHalt && ctrl_r.subOscPick;
    if (srcEdge) begin
      if (cnt_r >= halfTarget(act_r.divCode)) begin
        cnt_nxt = '0;
        if (!sysClk_r && pending) begin
          // Low phase is stretched, never cut short
          act_nxt     = want;
          srcPrev_nxt = srcLevel(want, oscSync);
        end else begin
          sysClk_nxt = !sysClk_r;
        end
      end else begin
        cnt_nxt = cnt_r + SCSP_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      act_r            <= '{fastSel: 1'b0, fastSourcePick: 1'b0,
                            subOscPick: 1'b0, slowSourcePick: 1'b0,
                            subOscHalt: 1'b0, divCode: SCSP_DIV_RESET};
      cnt_r            <= '0;
      srcPrev_r        <= 1'b0;
      sysClk_r         <= 1'b0;
      fastRcRun_r      <= 1'b1;
      fastCrystalRun_r <= 1'b0;
      fastXtalPins_r   <= 1'b0;
      slowXtalPins_r   <= 1'b0;
    end else begin
      act_r            <= act_nxt;
      cnt_r            <= cnt_nxt;
      srcPrev_r        <= srcPrev_nxt;
      sysClk_r         <= sysClk_nxt;
      fastRcRun_r      <= fastRcRun_nxt;
      fastCrystalRun_r <= fastCrystalRun_nxt;
      fastXtalPins_r   <= ctrl_r.subOscPick;
      slowXtalPins_r   <= ctrl_r.slowSourcePick;
    end
  end

  // Helper: source edges seen in each phase of the system clock
  logic [5:0] highEdges_r;
  logic [5:0] highEdges_nxt;
  logic [5:0] lowEdges_r;
  logic [5:0] lowEdges_nxt;

  always_comb begin
    highEdges_nxt = 6'h00;
    lowEdges_nxt  = 6'h00;
    if (sysClk_r) begin
      highEdges_nxt = highEdges_r + (srcEdge ? 6'h01 : 6'h00);
    end else begin
      // Saturates, since a stretched low phase has no upper bound
      lowEdges_nxt = lowEdges_r;
      if (srcEdge && (lowEdges_r != 6'h3F)) begin
        lowEdges_nxt = lowEdges_r + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      highEdges_r <= 6'h00;
      lowEdges_r  <= 6'h00;
    end else begin
      highEdges_r <= highEdges_nxt;
      lowEdges_r  <= lowEdges_nxt;
    end
  end

  property p_reset_value;
    @(posedge mclk) rst |=> (ctrl_r == SCSP_CTRL_RESET) && !sysClk_r;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("Control register wrong after reset");

  property p_fast_source_lock;
    @(posedge mclk) disable iff (rst)
      (ctrlWr && ctrl_r.sysclkFastPick) |=>
        ctrl_r.fastSourcePick == $past(ctrl_r.fastSourcePick);
  endproperty
  a_fast_source_lock: assert property (p_fast_source_lock)
    else $error("Fast source bit changed in fast mode");

  property p_sub_osc_lock;
    @(posedge mclk) disable iff (rst)
      (ctrlWr && ctrl_r.sysclkFastPick) |=>
        ctrl_r.subOscPick == $past(ctrl_r.subOscPick);
  endproperty
  a_sub_osc_lock: assert property (p_sub_osc_lock)
    else $error("Sub oscillator bit changed in fast mode");

  property p_sysclk_lock;
    @(posedge mclk) disable iff (rst)
      (ctrlWr && ctrl_r.subOscHalt && !ctrl_r.fastSourcePick) |=>
        $stable(ctrl_r.sysclkFastPick);
  endproperty
  a_sysclk_lock: assert property (p_sysclk_lock)
    else $error("System clock select changed while locked");

  property p_slow_source_lock;
    @(posedge mclk) disable iff (rst)
      (ctrlWr && !ctrl_r.sysclkFastPick) |=> $stable(ctrl_r.slowSourcePick);
  endproperty
  a_slow_source_lock: assert property (p_slow_source_lock)
    else $error("Slow source bit changed in slow mode");

  property p_halt_lock;
    @(posedge mclk) disable iff (rst)
      (ctrlWr && ctrl_r.sysclkFastPick && !ctrl_r.fastSourcePick) |=>
        $stable(ctrl_r.subOscHalt);
  endproperty
  a_halt_lock: assert property (p_halt_lock)
    else $error("Halt bit changed while locked");

  property p_divider_free;
    @(posedge mclk) disable iff (rst)
      ctrlWr |=> ctrl_r.sysclkDivider == $past(regWrData[2:0]);
  endproperty
  a_divider_free: assert property (p_divider_free)
    else $error("Divider field not written");

  sequence s_halt_set;
    ctrl_r.subOscHalt;
  endsequence
  sequence s_fast_stopped;
    !fastRcRun_r && !fastCrystalRun_r;
  endsequence
  property p_halt_stops;
    @(posedge mclk) disable iff (rst) s_halt_set |=> s_fast_stopped;
  endproperty
  a_halt_stops: assert property (p_halt_stops)
    else $error("Fast oscillators still running while halted");

  property p_switch_low;
    @(posedge mclk) disable iff (rst) $changed(act_r) |-> !sysClk_r;
  endproperty
  a_switch_low: assert property (p_switch_low)
    else $error("Clock source switched while output high");

  property p_high_length;
    @(posedge mclk) disable iff (rst)
      ($fell(sysClk_r) && $stable(act_r)) |->
        $past(highEdges_r) == 6'(halfTarget(act_r.divCode));
  endproperty
  a_high_length: assert property (p_high_length)
    else $error("High phase length does not match divider");

  property p_low_length;
    @(posedge mclk) disable iff (rst)
      $rose(sysClk_r) |->
        $past(lowEdges_r) >= 6'(halfTarget(act_r.divCode));
  endproperty
  a_low_length: assert property (p_low_length)
    else $error("Low phase shorter than divider allows");

endmodule // scsp_top

// File: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import scsp_pkg::*;

  logic         mclk;
  logic         rst = 1'b1;
  logic [7:0]   regAddr = 8'h00;
  logic [7:0]   regWrData = 8'h00;
  logic         regWrStrobe = 1'b0;
  logic         regRdStrobe = 1'b0;
  logic [7:0]   regRdData_r;
  scsp_osc_type oscIn = '0;
  logic         fastRcRun_r;
  logic         fastCrystalRun_r;
  logic         fastXtalPins_r;
  logic         slowXtalPins_r;
  logic         sysClk_r;
  int           failCount = 0;
  int           checksDone = 0;
  int           cyc = 0;
  int           per;
  logic [7:0]   model;
  logic [7:0]   got;
  // Locked writes first, then every source, then divider codes 0 to 5
  logic [7:0]   seqW [22] = '{8'hFF, 8'h05, 8'h15, 8'h25, 8'h75, 8'h15,
    8'h55, 8'h75, 8'hFD, 8'h55, 8'hD5, 8'hF5, 8'hFD, 8'hDD, 8'h5D,
    8'h7D, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55};

  scsp_top #(.ADDR_W(8)) i_scsp_top (
    .mclk             (mclk),
    .rst              (rst),
    .regAddr          (regAddr),
    .regWrData        (regWrData),
    .regWrStrobe      (regWrStrobe),
    .regRdStrobe      (regRdStrobe),
    .regRdData_r      (regRdData_r),
    .oscIn            (oscIn),
    .fastRcRun_r      (fastRcRun_r),
    .fastCrystalRun_r (fastCrystalRun_r),
    .fastXtalPins_r   (fastXtalPins_r),
    .slowXtalPins_r   (slowXtalPins_r),
    .sysClk_r         (sysClk_r)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Distinct half periods so each source shows its own period
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 0) oscIn.slowRc <= ~oscIn.slowRc;
    if (cyc % 5 == 0) oscIn.slowCrystal <= ~oscIn.slowCrystal;
    if (cyc % 3 == 0) oscIn.fastRc <= ~oscIn.fastRc;
    if (cyc % 6 == 0) oscIn.fastCrystal <= ~oscIn.fastCrystal;
    if (cyc % 7 == 0) oscIn.resistanceFreq <= ~oscIn.resistanceFreq;
    if (cyc == 30000) begin
      failCount++;
      completeRun();
    end
  end

  task completeRun;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task cmp(input string nm, input logic [15:0] exp, input logic [15:0] act);
    checksDone++;
    if (act !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, act);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge mclk);
    regWrStrobe <= 1'b0;
  endtask

  // Read data is valid one cycle only, then must return to zero
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge mclk);
    regRdStrobe <= 1'b0;
    #1 d = regRdData_r;
    @(posedge mclk);
    #1 cmp("rdIdle", 16'h0000, {8'h00, regRdData_r});
  endtask

  function automatic logic [7:0] nextCtrl(logic [7:0] o, logic [7:0] w);
    logic [7:0] n;
    n = {o[7:3], w[2:0]};
    if (!o[5]) n[7:6] = w[7:6];
    if (!o[3] || o[7]) n[5] = w[5];
    if (o[5]) n[4] = w[4];
    if (!o[5] || o[7]) n[3] = w[3];
    return n;
  endfunction

  function automatic int period(logic [7:0] m);
    int h;
    int n;
    h = m[5] ? (m[7] ? 7 : (m[6] ? 6 : 3)) : (m[4] ? 5 : 4);
    n = (m[2:0] <= 3'h5) ? (32 >> m[2:0]) : 1;
    return 2 * n * h;
  endfunction

  task checkPins(input logic [7:0] m);
    cmp("pins", {12'h000, m[6], m[4], !m[3] & !m[6], !m[3] & m[6]},
        {12'h000, fastXtalPins_r, slowXtalPins_r, fastRcRun_r,
         fastCrystalRun_r});
  endtask

  // Cycles from the call to the next rising edge of the system clock
  task riseWait(output int c);
    logic prev;
    prev = sysClk_r;
    for (c = 1; c < 1000; c++) begin
      @(posedge mclk);
      #1;
      if (!prev && sysClk_r) break;
      prev = sysClk_r;
    end
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    model = 8'h05;
    rd(SCSP_CTRL_OFFSET, got);
    cmp("ctrl", 16'h0005, {8'h00, got});
    checkPins(model);
    for (int i = 0; i < 22; i++) begin
      wr(SCSP_CTRL_OFFSET, seqW[i]);
      model = nextCtrl(model, seqW[i]);
      rd(SCSP_CTRL_OFFSET, got);
      cmp("ctrl", {8'h00, model}, {8'h00, got});
      checkPins(model);
      // Switching waits for a period boundary, so let it settle first
      repeat (3) riseWait(per);
      riseWait(per);
      cmp("period", 16'(period(model)), 16'(per));
      rd(SCSP_STATUS_OFFSET, got);
      cmp("status", {8'h00, 1'b0, model[5], model[2:0], 3'h0},
          {8'h00, got});
    end
    wr(8'h00, 8'hFF);
    rd(8'h00, got);
    cmp("unmapped", 16'h0000, {8'h00, got});
    rd(SCSP_CTRL_OFFSET, got);
    cmp("ctrl", {8'h00, model}, {8'h00, got});
    // Reset again mid-run: every field must return to its reset value
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(SCSP_CTRL_OFFSET, got);
    cmp("ctrlRst", 16'h0005, {8'h00, got});
    checkPins(8'h05);
    completeRun();
  end
endmodule // testbench
